// File: verilog/lpm_pkg.sv
// Package of constants and types for the low-power mode controller
// Notes on behaviour
// - In PHY-off suspend the PHY is off, USB is held suspended, clocks stop and PLLs are off.
// - PHY-off suspend is entered on request of on-chip firmware or of an external mailbox write.
// - In PHY-off suspend all pins keep driving their last value and USB keeps its last state.
// - In PHY-off suspend configuration, buffer memory and internal RAM stay unchanged.
// - Suspend is entered only after bus transactions are done; leftovers are not kept.
// - PHY-off suspend ends on D+ or D- change, ID change, SS resume, VBUS, CTS, line 0 or reset.
// - A wake from PHY-off suspend other than by reset leaves the program counter alone.
// - Standby wakes only on VBUS, CTS level of chosen polarity, control line 0 or reset.
// - Any wake from standby resets the program counter and restarts the powered-down core.
// - In standby the crystal oscillator, the PLL and the USB transceiver are off.
// - In standby GPIO pins keep the configuration they had before entry.
// - Core power-down loses all contents; exit is supply return or reset, then reload.
// - Each pin can be tristate, pulled up or pulled down, and holds its value in low power.
// - Drive strength is full, three-quarter, half or quarter, set per interface.
// - Unused control lines except line 15, and unused serial pins, can serve as GPIO.
package lpm_pkg;

    localparam logic [7:0] CTRL_OFFSET     = 8'h00;
    localparam logic [7:0] MAILBOX_OFFSET  = 8'h04;
    localparam logic [7:0] STATUS_OFFSET   = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFFSET = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;
    localparam logic [7:0] PULL_OFFSET     = 8'h14;
    localparam logic [7:0] DRIVE_OFFSET    = 8'h18;
    localparam logic [7:0] GPIO_SEL_OFFSET = 8'h1c;
    localparam logic [7:0] GPIO_OUT_OFFSET = 8'h20;

    // Control register fields
    localparam int CTRL_SUSPEND_BIT = 0;
    localparam int CTRL_STANDBY_BIT = 1;
    localparam int CTRL_CTS_POL_BIT = 2;
    localparam int MAILBOX_SUSPEND_BIT = 0;

    // Interrupt status fields
    localparam int IRQ_ENTERED_BIT = 0;
    localparam int IRQ_WOKE_BIT    = 1;
    localparam int IRQ_WIDTH       = 2;

    localparam int NUM_PINS     = 16;
    localparam int NUM_IFACES   = 4;
    localparam int NUM_CTL      = 16;
    localparam int NUM_SERIAL   = 8;
    localparam int CTL_GPIO_LSB = 0;
    localparam int SER_GPIO_LSB = 16;
    localparam int CTL15_BIT    = 15;

    // Pull modes, two bits per pin
    localparam logic [1:0] PULL_TRISTATE = 2'h0;
    localparam logic [1:0] PULL_UP       = 2'h1;
    localparam logic [1:0] PULL_DOWN     = 2'h2;

    // Drive strengths, two bits per interface
    localparam logic [1:0] DRIVE_FULL    = 2'h0;
    localparam logic [1:0] DRIVE_3Q      = 2'h1;
    localparam logic [1:0] DRIVE_HALF    = 2'h2;
    localparam logic [1:0] DRIVE_QUARTER = 2'h3;

    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] PULL_RESET     = 32'h5555_5555;
    localparam logic [31:0] DRIVE_RESET    = 32'h0000_0000;
    localparam logic [31:0] GPIO_SEL_RESET = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Clock and PLL restart time
    localparam int CLK_PERIOD_PS    = 4000;
    localparam int RESTART_TIME_NS  = 1000;
    localparam int RESTART_CYCLES   = (RESTART_TIME_NS * 1000) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_DRAIN   = 3'b001,
        ST_SUSPEND = 3'b010,
        ST_STANDBY = 3'b011,
        ST_RESTART = 3'b100
    } lpm_state_type;

    typedef struct packed {
        logic dp_line;
        logic dm_line;
        logic role_identity_pin;
        logic superspeed_receive_pair_resume;
        logic vbus_detect;
        logic cts_level;
        logic interface_control_line_0;
        logic ext_reset_n;
    } lpm_wake_type;

    typedef struct packed {
        logic phy_enable;
        logic usb_suspend;
        logic clocks_run;
        logic pll_enable;
        logic xtal_enable;
        logic usb_xcvr_enable;
        logic core_power;
        logic pad_hold;
    } lpm_power_type;

endpackage : lpm_pkg

// File: verilog/lpm_ctrl.sv
// Low-power mode controller with AXI4-Lite registers and pad configuration
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
module lpm_ctrl
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [7:0]                    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [7:0]                    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          bus_idle,
    input  wire lpm_pkg::lpm_wake_type         wake_in,
    output lpm_pkg::lpm_power_type             power_out,
    output logic                               cpu_pc_reset,
    output logic [2*lpm_pkg::NUM_PINS-1:0]     pad_pull,
    output logic [2*lpm_pkg::NUM_IFACES-1:0]   pad_drive,
    output logic [lpm_pkg::NUM_CTL-1:0]        ctl_gpio_en,
    output logic [lpm_pkg::NUM_SERIAL-1:0]     serial_gpio_en,
    output logic [lpm_pkg::NUM_PINS-1:0]       gpio_out,
    output logic                               irq
);
    import lpm_pkg::*;

    lpm_state_type                   state_reg;
    lpm_state_type                   state_next;
    logic [31:0]                     ctrl_reg;
    logic                            mailbox_reg;
    logic [31:0]                     pull_reg;
    logic [31:0]                     drive_reg;
    logic [31:0]                     gpio_sel_reg;
    logic [NUM_PINS-1:0]             gpio_out_reg;
    logic [IRQ_WIDTH-1:0]            irq_stat_reg;
    logic [IRQ_WIDTH-1:0]            irq_mask_reg;
    logic                            irq_reg;
    logic                            target_standby_reg;
    lpm_wake_type                    wake_prev_reg;
    lpm_wake_type                    wake_src_reg;
    logic [15:0]                     restart_cnt_reg;
    lpm_power_type                   power_reg;
    logic                            pc_reset_reg;
    logic                            awready_reg;
    logic                            wready_reg;
    logic                            bvalid_reg;
    logic [1:0]                      bresp_reg;
    logic                            arready_reg;
    logic                            rvalid_reg;
    logic [1:0]                      rresp_reg;
    logic [31:0]                     rdata_reg;
    logic                            wr_fire;
    logic                            rd_fire;
    logic                            wr_mapped;
    logic                            rd_mapped;
    logic [31:0]                     wr_mask;
    logic [31:0]                     rd_value;
    logic                            run_mode;
    lpm_wake_type                    suspend_hits;
    lpm_wake_type                    standby_hits;
    lpm_wake_type                    wake_hits;
    logic                            wake_any;
    logic                            enter_req;
    logic [IRQ_WIDTH-1:0]            irq_set;
    logic [IRQ_WIDTH-1:0]            irq_clr;

    assign run_mode = (state_reg == ST_RUN);

    // Write taken when address and data are both offered
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
    assign rd_fire = s_axi_arvalid && !arready_reg && !rvalid_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_strb
            assign wr_mask[8*gi +: 8] = {8{s_axi_wstrb[gi]}};
        end
    endgenerate

    always_comb
    begin
        if (s_axi_awaddr == CTRL_OFFSET || s_axi_awaddr == MAILBOX_OFFSET)
            wr_mapped = 1'b1;
        else if (s_axi_awaddr == STATUS_OFFSET || s_axi_awaddr == IRQ_STAT_OFFSET)
            wr_mapped = 1'b1;
        else if (s_axi_awaddr == IRQ_MASK_OFFSET || s_axi_awaddr == PULL_OFFSET)
            wr_mapped = 1'b1;
        else if (s_axi_awaddr == DRIVE_OFFSET || s_axi_awaddr == GPIO_SEL_OFFSET)
            wr_mapped = 1'b1;
        else if (s_axi_awaddr == GPIO_OUT_OFFSET)
            wr_mapped = 1'b1;
        else
            wr_mapped = 1'b0;
    end

    always_comb
    begin
        rd_mapped = 1'b1;
        rd_value  = 32'h0000_0000;
        if (s_axi_araddr == CTRL_OFFSET)
            rd_value = ctrl_reg;
        else if (s_axi_araddr == MAILBOX_OFFSET)
            rd_value = {31'h0000_0000, mailbox_reg};
        else if (s_axi_araddr == STATUS_OFFSET)
            rd_value = {21'h00_0000, wake_src_reg, state_reg};
        else if (s_axi_araddr == IRQ_STAT_OFFSET)
            rd_value = {30'h0000_0000, irq_stat_reg};
        else if (s_axi_araddr == IRQ_MASK_OFFSET)
            rd_value = {30'h0000_0000, irq_mask_reg};
        else if (s_axi_araddr == PULL_OFFSET)
            rd_value = pull_reg;
        else if (s_axi_araddr == DRIVE_OFFSET)
            rd_value = {24'h00_0000, drive_reg[7:0]};
        else if (s_axi_araddr == GPIO_SEL_OFFSET)
            rd_value = gpio_sel_reg;
        else if (s_axi_araddr == GPIO_OUT_OFFSET)
            rd_value = {16'h0000, gpio_out_reg};
        else
            rd_mapped = 1'b0;
    end

    // Write channel handshake and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end
        else
        begin
            awready_reg <= wr_fire;
            wready_reg  <= wr_fire;
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    // Read channel handshake and data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
        end
        else
        begin
            arready_reg <= rd_fire;
            if (rd_fire)
            begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                rdata_reg  <= rd_value;
            end
            else if (rvalid_reg && s_axi_rready)
                rvalid_reg <= 1'b0;
        end
    end

    // Configuration frozen outside run mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg     <= CTRL_RESET;
            pull_reg     <= PULL_RESET;
            drive_reg    <= DRIVE_RESET;
            gpio_sel_reg <= GPIO_SEL_RESET;
            gpio_out_reg <= 16'h0000;
            irq_mask_reg <= 2'h0;
        end
        else if (wr_fire && run_mode)
        begin
            if (s_axi_awaddr == CTRL_OFFSET)
                ctrl_reg <= (ctrl_reg & ~wr_mask) | (s_axi_wdata & wr_mask);
            else if (s_axi_awaddr == PULL_OFFSET)
                pull_reg <= (pull_reg & ~wr_mask) | (s_axi_wdata & wr_mask);
            else if (s_axi_awaddr == DRIVE_OFFSET)
                drive_reg <= (drive_reg & ~wr_mask) | (s_axi_wdata & wr_mask);
            else if (s_axi_awaddr == GPIO_SEL_OFFSET)
                gpio_sel_reg <= (gpio_sel_reg & ~wr_mask) | (s_axi_wdata & wr_mask);
            else if (s_axi_awaddr == GPIO_OUT_OFFSET && s_axi_wstrb[0])
                gpio_out_reg[7:0] <= s_axi_wdata[7:0];
            else if (s_axi_awaddr == IRQ_MASK_OFFSET && s_axi_wstrb[0])
                irq_mask_reg <= s_axi_wdata[IRQ_WIDTH-1:0];
            if (s_axi_awaddr == GPIO_OUT_OFFSET && s_axi_wstrb[1])
                gpio_out_reg[15:8] <= s_axi_wdata[15:8];
        end
        else if (state_reg == ST_DRAIN || state_reg == ST_RESTART)
            ctrl_reg[CTRL_STANDBY_BIT:CTRL_SUSPEND_BIT] <= 2'h0;
    end

    // External processor mailbox request
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mailbox_reg <= 1'b0;
        else if (wr_fire && run_mode && s_axi_awaddr == MAILBOX_OFFSET && s_axi_wstrb[0])
            mailbox_reg <= s_axi_wdata[MAILBOX_SUSPEND_BIT];
        else if (state_reg == ST_DRAIN)
            mailbox_reg <= 1'b0;
    end

    assign enter_req = ctrl_reg[CTRL_SUSPEND_BIT] || ctrl_reg[CTRL_STANDBY_BIT]
                       || mailbox_reg;

    // Wake qualification per state
    always_comb
    begin
        suspend_hits = '0;
        suspend_hits.dp_line = wake_in.dp_line ^ wake_prev_reg.dp_line;
        suspend_hits.dm_line = wake_in.dm_line ^ wake_prev_reg.dm_line;
        suspend_hits.role_identity_pin =
            wake_in.role_identity_pin ^ wake_prev_reg.role_identity_pin;
        suspend_hits.superspeed_receive_pair_resume = wake_in.superspeed_receive_pair_resume;
        suspend_hits.vbus_detect = wake_in.vbus_detect;
        suspend_hits.cts_level = wake_in.cts_level == ctrl_reg[CTRL_CTS_POL_BIT];
        suspend_hits.interface_control_line_0 = wake_in.interface_control_line_0;
        suspend_hits.ext_reset_n = !wake_in.ext_reset_n;
        standby_hits = '0;
        standby_hits.vbus_detect = suspend_hits.vbus_detect;
        standby_hits.cts_level = suspend_hits.cts_level;
        standby_hits.interface_control_line_0 = suspend_hits.interface_control_line_0;
        standby_hits.ext_reset_n = suspend_hits.ext_reset_n;
        if (state_reg == ST_SUSPEND)
            wake_hits = suspend_hits;
        else if (state_reg == ST_STANDBY)
            wake_hits = standby_hits;
        else
            wake_hits = '0;
    end

    assign wake_any = |wake_hits;

    // Previous pin levels for transition detection
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wake_prev_reg <= '0;
        else
            wake_prev_reg <= wake_in;
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN:
                if (enter_req)
                    state_next = ST_DRAIN;
            ST_DRAIN:
                if (bus_idle && !bvalid_reg && !rvalid_reg)
                    state_next = target_standby_reg ? ST_STANDBY : ST_SUSPEND;
            ST_SUSPEND:
                if (wake_any)
                    state_next = ST_RESTART;
            ST_STANDBY:
                if (wake_any)
                    state_next = ST_RESTART;
            ST_RESTART:
                if (restart_cnt_reg == 16'h0000)
                    state_next = ST_RUN;
            default:
                state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_reg <= ST_RUN;
        else
            state_reg <= state_next;
    end

    // Target low-power state chosen at entry
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            target_standby_reg <= 1'b0;
        else if (run_mode && enter_req)
            target_standby_reg <= ctrl_reg[CTRL_STANDBY_BIT] && !ctrl_reg[CTRL_SUSPEND_BIT]
                                  && !mailbox_reg;
    end

    // First wake source latched, restart timer loaded
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wake_src_reg    <= '0;
            restart_cnt_reg <= 16'h0000;
        end
        else if (wake_any && state_reg != ST_RESTART)
        begin
            wake_src_reg    <= wake_hits;
            restart_cnt_reg <= 16'(RESTART_CYCLES - 1);
        end
        else if (state_reg == ST_RESTART && restart_cnt_reg != 16'h0000)
            restart_cnt_reg <= restart_cnt_reg - 16'h0001;
    end

    // Power, clock and pad hold controls
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            power_reg <= '{phy_enable: 1'b1, usb_suspend: 1'b0, clocks_run: 1'b1,
                           pll_enable: 1'b1, xtal_enable: 1'b1, usb_xcvr_enable: 1'b1,
                           core_power: 1'b1, pad_hold: 1'b0};
        end
        else if (state_next == ST_SUSPEND)
        begin
            power_reg.phy_enable  <= 1'b0;
            power_reg.usb_suspend <= 1'b1;
            power_reg.clocks_run  <= 1'b0;
            power_reg.pll_enable  <= 1'b0;
            power_reg.pad_hold    <= 1'b1;
        end
        else if (state_next == ST_STANDBY)
        begin
            power_reg.phy_enable      <= 1'b0;
            power_reg.clocks_run      <= 1'b0;
            power_reg.pll_enable      <= 1'b0;
            power_reg.xtal_enable     <= 1'b0;
            power_reg.usb_xcvr_enable <= 1'b0;
            power_reg.core_power      <= 1'b0;
            power_reg.pad_hold        <= 1'b1;
        end
        else if (state_next == ST_RESTART)
        begin
            power_reg.xtal_enable     <= 1'b1;
            power_reg.pll_enable      <= 1'b1;
            power_reg.usb_xcvr_enable <= 1'b1;
            power_reg.core_power      <= 1'b1;
        end
        else if (state_next == ST_RUN)
        begin
            power_reg.clocks_run  <= 1'b1;
            power_reg.phy_enable  <= 1'b1;
            power_reg.usb_suspend <= 1'b0;
            power_reg.pad_hold    <= 1'b0;
        end
    end

    // Program counter reset on return to run after standby or after a reset wake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pc_reset_reg <= 1'b0;
        else if (state_reg == ST_RESTART && state_next == ST_RUN)
            pc_reset_reg <= target_standby_reg || wake_src_reg.ext_reset_n;
        else
            pc_reset_reg <= 1'b0;
    end

    assign irq_set[IRQ_ENTERED_BIT] = state_reg == ST_DRAIN && state_next != ST_DRAIN;
    assign irq_set[IRQ_WOKE_BIT]    = state_reg == ST_RESTART && state_next == ST_RUN;
    assign irq_clr = (wr_fire && s_axi_awaddr == IRQ_STAT_OFFSET && s_axi_wstrb[0]) ?
                     s_axi_wdata[IRQ_WIDTH-1:0] : 2'h0;

    // Sticky status, set beats clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_reg <= 2'h0;
            irq_reg      <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
            irq_reg      <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign power_out     = power_reg;
    assign cpu_pc_reset  = pc_reset_reg;
    assign pad_pull      = pull_reg;
    assign pad_drive     = drive_reg[2*NUM_IFACES-1:0];
    assign ctl_gpio_en   = gpio_sel_reg[CTL_GPIO_LSB +: NUM_CTL] & 16'h7fff;
    assign serial_gpio_en = gpio_sel_reg[SER_GPIO_LSB +: NUM_SERIAL];
    assign gpio_out      = gpio_out_reg;
    assign irq           = irq_reg;

endmodule : lpm_ctrl

// File: sim/lpm_ctrl_asserts.sv
// Port checker for the low-power mode controller
module lpm_ctrl_asserts
(
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wready,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 bus_idle,
    input wire lpm_pkg::lpm_power_type power_out,
    input wire logic                 cpu_pc_reset,
    input wire logic [31:0]          pad_pull,
    input wire logic [15:0]          ctl_gpio_en,
    input wire logic [15:0]          gpio_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import lpm_pkg::*;
    localparam int LO = RESTART_CYCLES - 1;
    localparam int HI = RESTART_CYCLES + 1;
    logic [9:0] cnt_reg;
    // Cycles spent restarting: PLL on, clocks still stopped
    always_ff @(posedge aclk)
        if (!aresetn || power_out.clocks_run)
            cnt_reg <= '0;
        else if (power_out.pll_enable)
            cnt_reg <= cnt_reg + 10'h1;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_CTL15: assert property (ctl_gpio_en[CTL15_BIT] == 1'b0)
        else $error("line 15 offered as gpio");
    AST_SUSP: assert property (!power_out.clocks_run && !power_out.pll_enable && power_out.xtal_enable |->
        !power_out.phy_enable && power_out.usb_suspend && power_out.pad_hold)
        else $error("suspend outputs wrong");
    AST_XTAL: assert property (!power_out.xtal_enable |-> !power_out.pll_enable &&
        !power_out.usb_xcvr_enable && !power_out.core_power)
        else $error("standby outputs wrong");
    AST_DRAIN: assert property ($fell(power_out.clocks_run) |->
        $past(bus_idle) && !$past(s_axi_bvalid))
        else $error("entry with bus busy");
    AST_RESTART: assert property ($rose(power_out.clocks_run) |->
        cnt_reg inside {[LO:HI]})
        else $error("restart length wrong");
    AST_PC: assert property (cpu_pc_reset |-> $rose(power_out.clocks_run) ##1
        !cpu_pc_reset)
        else $error("pc reset misplaced");
    AST_HOLD: assert property (power_out.pad_hold && $past(power_out.pad_hold) |->
        $stable(pad_pull) && $stable(gpio_out))
        else $error("pads changed in hold");
    AST_AW: assert property (s_axi_awready |-> s_axi_wready && s_axi_bvalid ##1
        !s_axi_awready)
        else $error("write handshake wrong");
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata))
        else $error("read data not held");
    cover property ($rose(cpu_pc_reset));
    cover property ($fell(power_out.xtal_enable));
    cover property ($fell(power_out.clocks_run));
endmodule : lpm_ctrl_asserts

bind lpm_ctrl lpm_ctrl_asserts u_chk (.*);

// File: sim/lpm_host_model.sv
// Wake source and system bus idle model
module lpm_host_model
(
    input  wire logic           aclk,
    input  wire logic           busy,
    input  wire logic [7:0]     kick,
    output logic                bus_idle,
    output lpm_pkg::lpm_wake_type wake_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import lpm_pkg::*;
    logic [1:0] lag_reg;
    initial
    begin
        lag_reg = 2'h0;
        bus_idle = 1'b1;
        wake_in = 8'h05;
    end
    // Toggle selected levels; idle flag trails bus traffic
    always @(posedge aclk)
    begin
        wake_in <= wake_in ^ kick;
        lag_reg <= busy ? 2'h3 : lag_reg - 2'(lag_reg != 2'h0);
        bus_idle <= !busy && lag_reg == 2'h0;
    end
endmodule : lpm_host_model

// File: sim/low_power_mode_controller_tb.sv
// Bench for the low-power mode controller
module low_power_mode_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lpm_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, busy = 0, irq, cpu_pc_reset, bus_idle;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, kick = 0, pad_drive, serial_gpio_en;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, pad_pull, r;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, br;
    logic [15:0] ctl_gpio_en, gpio_out;
    lpm_wake_type wake_in;
    lpm_power_type power_out;
    int failures = 0, samples_checked = 0, pcs = 0, ex = 0, n;
    always #2 aclk = ~aclk;
    always @(posedge aclk) if (cpu_pc_reset === 1'b1) pcs <= pcs + 1;
    lpm_ctrl dut (.*);
    lpm_host_model host (.aclk(aclk), .busy(busy), .kick(kick), .bus_idle(bus_idle),
        .wake_in(wake_in));
    task print_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task tmo(input int c);
        if (c >= 999)
        begin
            failures++;
            $display("FAIL %0t no answer", $time);
            print_verdict();
        end
    endtask : tmo
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        n = 0;
        do begin @(posedge aclk); n++; end while (s_axi_awready !== 1'b1 && n < 999);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        while (s_axi_bvalid !== 1'b1 && n < 999) begin @(posedge aclk); n++; end
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        n = 0;
        do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 999);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1 && n < 999) begin @(posedge aclk); n++; end
        {r, br} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask : rd
    task wait_clk(input logic v);
        n = 0;
        do begin @(posedge aclk); n++; end while (power_out.clocks_run !== v && n < 999);
        @(posedge aclk);
        tmo(n);
    endtask : wait_clk
    task hit(input logic [7:0] k);
        kick <= k;
        @(posedge aclk);
        kick <= 8'h0;
    endtask : hit
    task nap(input logic [7:0] a, input logic [31:0] d, input logic [7:0] k);
        wr(a, d);
        wait_clk(1'b0);
        hit(k);
        wait_clk(1'b1);
        hit(k);
        ex += int'(k == 8'h01 || d == 32'h2);
        chk(pcs, ex);
    endtask : nap
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(PULL_OFFSET);
        chk(r, PULL_RESET);
        chk(power_out, 8'hbe);
        wr(DRIVE_OFFSET, 32'he4);
        wr(GPIO_SEL_OFFSET, 32'hff_ffff);
        wr(GPIO_OUT_OFFSET, 32'ha5c3);
        wr(IRQ_MASK_OFFSET, 32'h3);
        chk(pad_drive, 8'he4);
        chk({serial_gpio_en, ctl_gpio_en}, 32'hff7fff);
        rd(8'h40);
        chk({r, br}, {32'h0, RESP_SLVERR});
        wr(8'h40, 32'h1);
        chk(br, RESP_SLVERR);
        busy <= 1'b1;
        wr(CTRL_OFFSET, 32'h1);
        repeat (20) @(posedge aclk);
        chk(power_out.clocks_run, 1'b1);
        busy <= 1'b0;
        wait_clk(1'b0);
        chk(power_out, 8'h4f);
        wr(GPIO_OUT_OFFSET, 32'h0);
        chk(gpio_out, 16'ha5c3);
        hit(8'h80);
        wait_clk(1'b1);
        hit(8'h80);
        chk(pcs, 0);
        rd(IRQ_STAT_OFFSET);
        chk(r[1:0], 2'h3);
        wr(IRQ_STAT_OFFSET, 32'h3);
        rd(IRQ_STAT_OFFSET);
        chk({r[1:0], irq}, 3'h0);
        for (int i = 0; i < 8; i++) nap(i % 2 ? MAILBOX_OFFSET : CTRL_OFFSET, 1, 8'h80 >> i);
        wr(CTRL_OFFSET, 32'h2);
        wait_clk(1'b0);
        chk(power_out, 8'h01);
        hit(8'hf0);
        repeat (30) @(posedge aclk);
        chk(power_out.xtal_enable, 1'b0);
        hit(8'hf8);
        wait_clk(1'b1);
        hit(8'h08);
        chk(pcs, ++ex);
        for (int i = 5; i < 8; i++) nap(CTRL_OFFSET, 2, 8'h80 >> i);
        chk(pad_drive, 8'he4);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({pad_drive, gpio_out}, 24'h0);
        print_verdict();
    end
endmodule : low_power_mode_controller_tb
